//--- pkg/sfw_cfg.svh
// constants of the serial flash-write programming host
`ifndef SFW_CFG_SVH
`define SFW_CFG_SVH
`define SFW_MATCH          8'h5a
`define SFW_RATE_INIT      8'h28
`define SFW_CMD_WRITE      8'h30
`define SFW_ERR_RATE       8'h62
`define SFW_ERR_CMD        8'h63
`define SFW_REC_MARK       8'h3a
`define SFW_CLK_HZ         40000000
`define SFW_INIT_BPS       9600
`define SFW_INIT_DIV       ((`SFW_CLK_HZ + `SFW_INIT_BPS / 2) / `SFW_INIT_BPS)
`define SFW_ECHO_WAIT_BITS 40
`define SFW_SUM_WAIT_MS    200
`define SFW_SUM_WAIT       (`SFW_CLK_HZ / 1000 * `SFW_SUM_WAIT_MS)
`define SFW_MATCH_TRIES    8'hff
`define SFW_DATA_W         8
`define SFW_FIFO_DEPTH     8
`endif

//--- pkg/sfw_pkg.sv
// types of the serial flash-write programming host
package sfw_pkg;
    typedef struct packed
    {
        logic        resume;
        logic [7:0]  rate_code;
        logic [15:0] new_div;
        logic [15:0] cnt_addr;
        logic [15:0] pw_addr;
    } cfg_t;
    typedef struct packed
    {
        logic       last;
        logic [7:0] data;
    } fifo_word_t;
    typedef enum logic [3:0]
    {
        ST_IDLE     = 4'b0000,
        ST_MATCH_TX = 4'b0001,
        ST_MATCH_W  = 4'b0010,
        ST_RATE_TX  = 4'b0011,
        ST_RATE_W   = 4'b0100,
        ST_CMD_TX   = 4'b0101,
        ST_CMD_W    = 4'b0110,
        ST_ADDR     = 4'b0111,
        ST_DATA     = 4'b1000,
        ST_SUM_H    = 4'b1001,
        ST_SUM_L    = 4'b1010
    } state_t;
    typedef enum logic [2:0]
    {
        ERR_NONE     = 3'b000,
        ERR_NO_MATCH = 3'b001,
        ERR_RATE     = 3'b010,
        ERR_CMD      = 3'b011,
        ERR_TIMEOUT  = 3'b100
    } err_t;
endpackage : sfw_pkg

//--- rtl/sfw_host.sv
// programming host: byte fifo and link sequencer for the flash-write command
`timescale 1ns/10ps
`include "sfw_cfg.svh"

module sfw_fifo #(
    parameter int W     = 9,
    parameter int DEPTH = 8
) (
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic         in_valid,
    input  wire logic [W-1:0] in_data,
    output logic              in_ready,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    logic [W-1:0]  mem_r [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic          push;
    logic          pop;
    logic          rdy_r;

    assign push      = in_valid && rdy_r;
    assign pop       = out_ready && (cnt_r != '0);
    assign out_valid = (cnt_r != '0);
    assign out_data  = mem_r[rp_r];
    assign in_ready  = rdy_r;
    assign cnt_nxt   = cnt_r + CW'(push) - CW'(pop);

    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem_r[wp_r] <= in_data;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
            rdy_r <= 1'b0;
        end
        else
        begin
            if (push)
            begin
                wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
            end
            if (pop)
            begin
                rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
            end
            cnt_r <= cnt_nxt;
            // registered ready: full is known one cycle ahead, never overfills
            rdy_r <= (cnt_nxt != CW'(DEPTH));
        end
    end
endmodule : sfw_fifo

module sfw_host #(
    parameter logic [15:0] INIT_DIV  = 16'(`SFW_INIT_DIV),
    parameter logic [23:0] ECHO_WAIT = 24'(`SFW_ECHO_WAIT_BITS * `SFW_INIT_DIV),
    parameter logic [23:0] SUM_WAIT  = 24'(`SFW_SUM_WAIT)
) (
    input  wire logic      clk,
    input  wire logic      nrst,
    input  wire logic      start,
    input  sfw_pkg::cfg_t  cfg,
    input  wire logic      in_valid,
    input  sfw_pkg::fifo_word_t in_word,
    output logic           in_ready,
    input  wire logic      rxd,
    output logic           txd,
    output logic           busy,
    output logic           done,
    output sfw_pkg::err_t  err,
    output logic [15:0]    sum
);
    import sfw_pkg::*;

    // ************************************************************
    // declarations
    // ************************************************************
    state_t      state_r;
    cfg_t        cfg_r;
    err_t        err_r;
    fifo_word_t  f_word;
    logic        f_valid;
    logic        pop;
    logic [15:0] cur_div_r;
    logic [23:0] timer_r;
    logic [7:0]  tries_r;
    logic [1:0]  idx_r;
    logic        tx_load_r;
    logic [7:0]  tx_byte_r;
    logic        tx_busy_r;
    logic [9:0]  tx_sh_r;
    logic [15:0] tx_cnt_r;
    logic [3:0]  tx_bit_r;
    logic        txd_r;
    logic        rx_s1_r;
    logic        rx_s2_r;
    logic        rx_busy_r;
    logic [15:0] rx_cnt_r;
    logic [3:0]  rx_bit_r;
    logic [7:0]  rx_sh_r;
    logic        rx_valid_r;
    logic [7:0]  rx_data_r;
    logic [15:0] sum_r;
    logic        done_r;
    logic        busy_r;
    logic        tx_free;
    logic        timeout;

    function automatic logic [7:0] addr_byte(input cfg_t c, input logic [1:0] i);
        case (i)
            2'h0:    addr_byte = c.cnt_addr[15:8];
            2'h1:    addr_byte = c.cnt_addr[7:0];
            2'h2:    addr_byte = c.pw_addr[15:8];
            default: addr_byte = c.pw_addr[7:0];
        endcase
    endfunction : addr_byte

    // ************************************************************
    // byte fifo: password bytes then hex records, last flag ends them
    // ************************************************************
    sfw_fifo #(.W($bits(fifo_word_t)), .DEPTH(`SFW_FIFO_DEPTH)) u_fifo (
        .clk       (clk),
        .nrst      (nrst),
        .in_valid  (in_valid),
        .in_data   (in_word),
        .in_ready  (in_ready),
        .out_valid (f_valid),
        .out_ready (pop),
        .out_data  (f_word)
    );

    assign tx_free = !tx_busy_r && !tx_load_r;
    assign pop     = (state_r == ST_DATA) && f_valid && tx_free;
    assign timeout = (timer_r == '0);

    // ************************************************************
    // transmitter, lsb first, one stop bit
    // ************************************************************
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            tx_busy_r <= 1'b0;
            tx_sh_r   <= 10'h3ff;
            tx_cnt_r  <= 16'h0000;
            tx_bit_r  <= 4'h0;
            txd_r     <= 1'b1;
        end
        else
        begin
            txd_r <= tx_busy_r ? tx_sh_r[0] : 1'b1;
            if (!tx_busy_r)
            begin
                if (tx_load_r)
                begin
                    tx_sh_r   <= {1'b1, tx_byte_r, 1'b0};
                    tx_busy_r <= 1'b1;
                    tx_cnt_r  <= 16'h0000;
                    tx_bit_r  <= 4'h0;
                end
            end
            else if (tx_cnt_r == cur_div_r - 16'h0001)
            begin
                tx_cnt_r <= 16'h0000;
                tx_sh_r  <= {1'b1, tx_sh_r[9:1]};
                if (tx_bit_r == 4'h9)
                begin
                    tx_busy_r <= 1'b0;
                end
                tx_bit_r <= tx_bit_r + 4'h1;
            end
            else
            begin
                tx_cnt_r <= tx_cnt_r + 16'h0001;
            end
        end
    end

    // ************************************************************
    // receiver, mid-bit sampling; a bad stop bit drops the byte
    // ************************************************************
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            rx_s1_r    <= 1'b1;
            rx_s2_r    <= 1'b1;
            rx_busy_r  <= 1'b0;
            rx_cnt_r   <= 16'h0000;
            rx_bit_r   <= 4'h0;
            rx_sh_r    <= 8'h00;
            rx_valid_r <= 1'b0;
            rx_data_r  <= 8'h00;
        end
        else
        begin
            rx_s1_r    <= rxd;
            rx_s2_r    <= rx_s1_r;
            rx_valid_r <= 1'b0;
            if (!rx_busy_r)
            begin
                if (!rx_s2_r)
                begin
                    rx_busy_r <= 1'b1;
                    rx_cnt_r  <= {1'b0, cur_div_r[15:1]};
                    rx_bit_r  <= 4'h0;
                end
            end
            else if (rx_cnt_r != 16'h0000)
            begin
                rx_cnt_r <= rx_cnt_r - 16'h0001;
            end
            else
            begin
                rx_cnt_r <= cur_div_r - 16'h0001;
                rx_bit_r <= rx_bit_r + 4'h1;
                if (rx_bit_r == 4'h0)
                begin
                    rx_busy_r <= !rx_s2_r;
                end
                else if (rx_bit_r == 4'h9)
                begin
                    rx_busy_r  <= 1'b0;
                    rx_valid_r <= rx_s2_r;
                    rx_data_r  <= rx_sh_r;
                end
                else
                begin
                    rx_sh_r <= {rx_s2_r, rx_sh_r[7:1]};
                end
            end
        end
    end

    // ************************************************************
    // sequencer
    // ************************************************************
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            state_r   <= ST_IDLE;
            cfg_r     <= '0;
            err_r     <= ERR_NONE;
            cur_div_r <= INIT_DIV;
            timer_r   <= 24'h000000;
            tries_r   <= 8'h00;
            idx_r     <= 2'h0;
            tx_load_r <= 1'b0;
            tx_byte_r <= 8'h00;
            sum_r     <= 16'h0000;
            done_r    <= 1'b0;
            busy_r    <= 1'b0;
        end
        else
        begin
            tx_load_r <= 1'b0;
            done_r    <= 1'b0;
            if (!timeout)
            begin
                timer_r <= timer_r - 24'h000001;
            end
            case (state_r)
                ST_IDLE:
                begin
                    busy_r <= 1'b0;
                    if (start)
                    begin
                        cfg_r   <= cfg;
                        err_r   <= ERR_NONE;
                        busy_r  <= 1'b1;
                        tries_r <= `SFW_MATCH_TRIES;
                        idx_r   <= 2'h0;
                        // a device that just sent its checksum takes a command directly
                        if (cfg.resume)
                        begin
                            state_r <= ST_CMD_TX;
                        end
                        else
                        begin
                            cur_div_r <= INIT_DIV;
                            state_r   <= ST_MATCH_TX;
                        end
                    end
                end
                ST_MATCH_TX:
                begin
                    if (tx_free && !rx_busy_r)
                    begin
                        tx_byte_r <= `SFW_MATCH;
                        tx_load_r <= 1'b1;
                        timer_r   <= ECHO_WAIT;
                        state_r   <= ST_MATCH_W;
                    end
                end
                ST_MATCH_W:
                begin
                    if (rx_valid_r && rx_data_r == `SFW_MATCH)
                    begin
                        state_r <= ST_RATE_TX;
                    end
                    else if (timeout || rx_valid_r)
                    begin
                        // silence or garbage: send the matching byte again, or give up with ERR_NO_MATCH once tries_r is zero
                        if (tries_r == 8'h00)
                        begin
                            err_r   <= ERR_NO_MATCH;
                            done_r  <= 1'b1;
                            state_r <= ST_IDLE;
                        end
                        else
                        begin
                            tries_r <= tries_r - 8'h01;
                            state_r <= ST_MATCH_TX;
                        end
                    end
                end
                ST_RATE_TX:
                begin
                    if (tx_free)
                    begin
                        tx_byte_r <= cfg_r.rate_code;
                        tx_load_r <= 1'b1;
                        timer_r   <= ECHO_WAIT;
                        state_r   <= ST_RATE_W;
                    end
                end
                ST_RATE_W:
                begin
                    if (rx_valid_r && rx_data_r == cfg_r.rate_code)
                    begin
                        // device switches after its echo, so we switch only now
                        cur_div_r <= cfg_r.new_div;
                        state_r   <= ST_CMD_TX;
                    end
                    else if (timeout || rx_valid_r)
                    begin
                        err_r   <= ERR_RATE;
                        done_r  <= 1'b1;
                        state_r <= ST_IDLE;
                    end
                end
                ST_CMD_TX:
                begin
                    if (tx_free && !rx_busy_r)
                    begin
                        tx_byte_r <= `SFW_CMD_WRITE;
                        tx_load_r <= 1'b1;
                        timer_r   <= ECHO_WAIT;
                        state_r   <= ST_CMD_W;
                    end
                end
                ST_CMD_W:
                begin
                    if (rx_valid_r && rx_data_r == `SFW_CMD_WRITE)
                    begin
                        state_r <= ST_ADDR;
                    end
                    else if (timeout || rx_valid_r)
                    begin
                        err_r   <= ERR_CMD;
                        done_r  <= 1'b1;
                        state_r <= ST_IDLE;
                    end
                end
                ST_ADDR:
                begin
                    // no answer follows these bytes, so they go back to back
                    if (tx_free)
                    begin
                        tx_byte_r <= addr_byte(cfg_r, idx_r);
                        tx_load_r <= 1'b1;
                        idx_r     <= idx_r + 2'h1;
                        if (idx_r == 2'h3)
                        begin
                            state_r <= ST_DATA;
                        end
                    end
                end
                ST_DATA:
                begin
                    // password bytes, if any, then records, all as queued
                    // not screened: erasing first and whole-region writes stay with the user
                    if (pop)
                    begin
                        tx_byte_r <= f_word.data;
                        tx_load_r <= 1'b1;
                        if (f_word.last)
                        begin
                            timer_r <= SUM_WAIT;
                            state_r <= ST_SUM_H;
                        end
                    end
                end
                ST_SUM_H:
                begin
                    // a halted device is silent; only the timer tells
                    if (rx_valid_r)
                    begin
                        sum_r[15:8] <= rx_data_r;
                        timer_r     <= ECHO_WAIT;
                        state_r     <= ST_SUM_L;
                    end
                    else if (timeout)
                    begin
                        err_r   <= ERR_TIMEOUT;
                        done_r  <= 1'b1;
                        state_r <= ST_IDLE;
                    end
                end
                ST_SUM_L:
                begin
                    if (rx_valid_r)
                    begin
                        sum_r[7:0] <= rx_data_r;
                        done_r     <= 1'b1;
                        state_r    <= ST_IDLE;
                    end
                    else if (timeout)
                    begin
                        err_r   <= ERR_TIMEOUT;
                        done_r  <= 1'b1;
                        state_r <= ST_IDLE;
                    end
                end
                default:
                begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    assign txd  = txd_r;
    assign busy = busy_r;
    assign done = done_r;
    assign err  = err_r;
    assign sum  = sum_r;

    // ************************************************************
    // checks
    // ************************************************************
    AST_MATCH_BYTE: assert property (@(posedge clk) disable iff (!nrst)
        tx_load_r && state_r == ST_MATCH_W |-> tx_byte_r == `SFW_MATCH)
        else $error("matching byte wrong");
    AST_RETRY: assert property (@(posedge clk) disable iff (!nrst)
        state_r == ST_MATCH_W && timeout && !rx_valid_r && tries_r != 8'h00
        |=> state_r == ST_MATCH_TX ##[1:8] state_r == ST_MATCH_W)
        else $error("matching byte not resent");
    AST_RATE_BYTE: assert property (@(posedge clk) disable iff (!nrst)
        tx_load_r && state_r == ST_RATE_W |-> tx_byte_r == cfg_r.rate_code)
        else $error("rate code wrong");
    AST_DIV_SWITCH: assert property (@(posedge clk) disable iff (!nrst)
        state_r == ST_RATE_W && rx_valid_r && rx_data_r == cfg_r.rate_code
        |=> cur_div_r == cfg_r.new_div && state_r == ST_CMD_TX)
        else $error("rate not switched after echo");
    AST_RATE_ERR: assert property (@(posedge clk) disable iff (!nrst)
        state_r == ST_RATE_W && rx_valid_r && rx_data_r != cfg_r.rate_code
        |=> err_r == ERR_RATE && done_r && $stable(cur_div_r))
        else $error("rate error missed");
    AST_CMD_BYTE: assert property (@(posedge clk) disable iff (!nrst)
        tx_load_r && state_r == ST_CMD_W |-> tx_byte_r == `SFW_CMD_WRITE)
        else $error("command byte wrong");
    AST_CMD_ERR: assert property (@(posedge clk) disable iff (!nrst)
        state_r == ST_CMD_W && rx_valid_r && rx_data_r != `SFW_CMD_WRITE
        |=> err_r == ERR_CMD && state_r == ST_IDLE)
        else $error("command error missed");
    AST_CNT_ADDR_HI: assert property (@(posedge clk) disable iff (!nrst)
        tx_load_r && state_r == ST_ADDR && idx_r == 2'h1
        |-> tx_byte_r == cfg_r.cnt_addr[15:8])
        else $error("count address order wrong");
    AST_PW_ADDR_LO: assert property (@(posedge clk) disable iff (!nrst)
        tx_load_r && state_r == ST_DATA && $past(state_r) == ST_ADDR
        |-> idx_r == 2'h0 && tx_byte_r == cfg_r.pw_addr[7:0])
        else $error("compare address order wrong");
    AST_SUM_LO: assert property (@(posedge clk) disable iff (!nrst)
        state_r == ST_SUM_L && rx_valid_r
        |=> done_r && sum_r[7:0] == $past(rx_data_r) && err_r == ERR_NONE)
        else $error("checksum low byte lost");
endmodule : sfw_host

//--- tb/sfw_dev_model.sv
// device-side model of the serial flash-write link
`timescale 1ns/10ps
module sfw_dev_model #(
    parameter int         DIV0     = 16,
    parameter int         DIV_ALT  = 8,
    parameter logic [7:0] RATE_ALT = 8'h18
) (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic rx_line,
    output logic      tx_line
);
    int          div;
    logic [15:0] cnt_a, pw_a, sum;
    logic [7:0]  mem [0:255];
    // ************
    // framing
    // ************
    // no stop-bit check: reception errors are never injected here
    // level wait: a start bit that began during our own stop bit is still caught
    task automatic get(output logic [7:0] b);
        wait (rx_line === 1'b0);
        repeat (div * 3 / 2) @(posedge clk);
        for (int i = 0; i < 8; i++)
        begin
            b[i] = rx_line;
            repeat (div) @(posedge clk);
        end
    endtask : get
    task automatic put(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            tx_line <= f[i];
            repeat (div) @(posedge clk);
        end
    endtask : put
    task automatic session();
        logic [7:0]  b, n, t, c;
        logic [15:0] a;
        // the first byte only trains rate detection and earns no echo
        get(b);
        b = 8'h00;
        while (b != 8'h5a) get(b);
        put(b);
        get(b);
        if (b != 8'h28 && b != RATE_ALT)
        begin
            repeat (3) put(8'h62);
            wait (1'b0);
        end
        put(b);
        div = (b == 8'h28) ? DIV0 : DIV_ALT;
        forever
        begin
            get(b);
            if (b != 8'h30)
            begin
                repeat (3) put(8'h63);
                wait (1'b0);
            end
            put(b);
            get(cnt_a[15:8]);
            get(cnt_a[7:0]);
            get(pw_a[15:8]);
            get(pw_a[7:0]);
            // blank part assumed: no password bytes expected
            sum = 16'h0000;
            t = 8'h00;
            while (t != 8'h01)
            begin
                b = 8'h00;
                while (b != 8'h3a) get(b);
                get(n);
                get(a[15:8]);
                get(a[7:0]);
                get(t);
                c = 8'(n + a[15:8] + a[7:0] + t);
                for (int i = 0; i < n; i++)
                begin
                    get(b);
                    mem[8'(a[7:0] + i)] = b;
                    sum = sum + 16'(b);
                    c = 8'(c + b);
                end
                get(b);
                if (8'(c + b) != 8'h00 || t > 8'h01)
                    wait (1'b0);
            end
            put(sum[15:8]);
            put(sum[7:0]);
        end
    endtask : session
    always
    begin
        tx_line = 1'b1;
        div = DIV0;
        wait (nrst === 1'b1);
        fork : life
            session();
            begin
                @(negedge nrst);
                disable life;
            end
        join
    end
endmodule : sfw_dev_model

//--- tb/sfw_host_tb.sv
// self-checking bench of the flash-write programming host
`timescale 1ns/10ps
module sfw_host_tb;
    import sfw_pkg::*;
    logic       clk, nrst, start, in_valid, in_ready, rxd, txd, busy, done;
    cfg_t       cfg;
    fifo_word_t in_word;
    err_t       err;
    logic [15:0] sum;
    int         errors = 0, num_checks = 0, cyc = 0;
    sfw_host #(.INIT_DIV(16'h0010), .ECHO_WAIT(24'h000280), .SUM_WAIT(24'h004e20)) u_sfw_host (
        .clk(clk), .nrst(nrst), .start(start), .cfg(cfg), .in_valid(in_valid),
        .in_word(in_word), .in_ready(in_ready), .rxd(rxd), .txd(txd), .busy(busy),
        .done(done), .err(err), .sum(sum));
    sfw_dev_model #(.DIV0(16), .DIV_ALT(8)) u_sfw_dev_model (
        .clk(clk), .nrst(nrst), .rx_line(txd), .tx_line(rxd));
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // ************
    // helpers
    // ************
    task automatic results();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : results
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic go(input cfg_t c, input logic rst);
        if (rst)
        begin
            @(negedge clk);
            nrst = 1'b0;
            repeat (4) @(negedge clk);
            nrst = 1'b1;
        end
        @(negedge clk);
        cfg = c;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
    endtask : go
    // waits for in_ready; the fifo refuses while full
    task automatic send(input logic [7:0] q [$]);
        int n;
        foreach (q[i])
        begin
            n = 0;
            @(negedge clk);
            in_valid = 1'b1;
            in_word = {i == q.size() - 1, q[i]};
            while (in_ready !== 1'b1 && n < 30000)
            begin
                @(negedge clk);
                n++;
            end
            if (n >= 30000)
            begin
                errors++;
                $display("[ERR] %0t fifo never ready", $time);
            end
            @(negedge clk);
            in_valid = 1'b0;
        end
    endtask : send
    task automatic wait_done(input err_t e, input logic [15:0] s);
        int n;
        n = 0;
        while (done !== 1'b1 && n < 40000)
        begin
            @(negedge clk);
            n++;
        end
        if (n >= 40000)
        begin
            errors++;
            $display("[ERR] %0t done never came", $time);
        end
        chk({13'h0000, err}, {13'h0000, e});
        chk({15'h0000, busy}, 16'h0001);
        if (e == ERR_NONE)
            chk(sum, s);
        @(negedge clk);
        chk({15'h0000, busy}, 16'h0000);
    endtask : wait_done
    // ************
    // scenarios
    // ************
    task automatic t_write();
        go('{1'b0, 8'h28, 16'h0010, 16'h1234, 16'h5678}, 1'b1);
        send('{8'h55, 8'h3a, 8'h02, 8'h00, 8'h10, 8'h00, 8'ha1, 8'hb2, 8'h9b,
               8'h3a, 8'h00, 8'h00, 8'h00, 8'h01, 8'hff});
        wait_done(ERR_NONE, 16'h0153);
        chk(u_sfw_dev_model.cnt_a, 16'h1234);
        chk(u_sfw_dev_model.pw_a, 16'h5678);
        chk({8'h00, u_sfw_dev_model.mem[17]}, 16'h00b2);
    endtask : t_write
    task automatic t_short(input logic [7:0] rate, input logic [15:0] dv, input logic rst,
                           input logic [7:0] rc, input err_t e, input logic [15:0] s);
        go('{~rst, rate, dv, 16'h0001, 16'h0002}, rst);
        if (e != ERR_RATE)
            send('{8'h3a, 8'h01, 8'h00, 8'h20, 8'h00, 8'h07, rc,
                   8'h3a, 8'h00, 8'h00, 8'h00, 8'h01, 8'hff});
        wait_done(e, s);
    endtask : t_short
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            errors++;
            results();
        end
    end
    initial
    begin
        nrst = 1'b0;
        start = 1'b0;
        in_valid = 1'b0;
        in_word = '0;
        cfg = '0;
        t_write();
        t_short(8'h28, 16'h0010, 1'b0, 8'hd8, ERR_NONE, 16'h0007);
        t_short(8'h18, 16'h0008, 1'b1, 8'hd8, ERR_NONE, 16'h0007);
        t_short(8'h28, 16'h0010, 1'b1, 8'h00, ERR_TIMEOUT, 16'h0000);
        t_short(8'h77, 16'h0010, 1'b1, 8'h00, ERR_RATE, 16'h0000);
        results();
    end
endmodule : sfw_host_tb
